// ==== design/acc_defs.svh ====
// Constants for the analog comparator control block: offsets, bit positions, reset values.
// Assumes inclusion by the package and the design modules of this block only.
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH
`define ACC_ADDR_W 4
`define ACC_OFF_CTRL 4'h0
`define ACC_OFF_CONVB 4'h1
`define ACC_OFF_DIDR 4'h2
`define ACC_OFF_CONVA 4'h3
`define ACC_OFF_CHAN 4'h4
`define ACC_OFF_PWR 4'h5
`define ACC_OFF_IRQ_STAT 4'h6
`define ACC_OFF_IRQ_MASK 4'h7
`define ACC_BIT_POWER_OFF 7
`define ACC_BIT_BANDGAP 6
`define ACC_BIT_OUT 5
`define ACC_BIT_FLAG 4
`define ACC_BIT_IRQ_EN 3
`define ACC_BIT_CAPTURE 2
`define ACC_BIT_NEG_MUX 6
`define ACC_BIT_CONV_ON 7
`define ACC_BIT_CONV_PWR 0
`define ACC_BIT_NEG_DIG 1
`define ACC_BIT_POS_DIG 0
`define ACC_RESET_BYTE 8'h00
`define ACC_CTRL_WMASK 8'hDF
`endif

// ==== design/acc_pkg.sv ====
// Types for the analog comparator control block.
// Assumes the constants header is on the include path.
`include "acc_defs.svh"
package acc_pkg;
    // Interrupt mode codes of the two-bit mode field.
    typedef enum logic [1:0] {
        ACC_MODE_TOGGLE = 2'h0,
        ACC_MODE_RESERVED = 2'h1,
        ACC_MODE_FALL = 2'h2,
        ACC_MODE_RISE = 2'h3
    } acc_mode_t;
    // Register bus request from software.
    typedef struct packed {
        logic [`ACC_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } acc_bus_req_t;
    // Analog front end selection driven to the comparator macro.
    typedef struct packed {
        logic power_off;
        logic pos_bandgap;
        logic neg_from_mux;
        logic [2:0] channel;
    } acc_analog_sel_t;
endpackage

// ==== design/acc_sync.sv ====
// Two flip-flop synchroniser with a registered edge history for the comparator output.
// Assumes an asynchronous raw input and a reset already released on clk.
module acc_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_q,
    output logic prev_q
);
    logic meta_q; // First stage, read only by the second stage.
    // Two stages bound metastability; the third keeps the previous value for edges.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end
endmodule

// ==== design/acc_top.sv ====
// Control logic of the on-chip analog comparator: input selection, synchronising,
// edge interrupt, timer capture routing, pin digital input gating, register port.
// Assumes the analog comparator result arrives asynchronously on cmp_raw.
//
// Chosen here: the plain strobed port and the address map.
`include "acc_defs.svh"
// Notes on behaviour
// - Raw result high when positive exceeds negative.
// - Output status bit synchronised, one-two cycle latency.
// - Disable bit seven switches comparator power off.
// - Bit six selects bandgap as positive input.
// - Flag set on chosen synchronised output event.
// - Flag cleared by vector or writing one.
// - Request needs flag, enable and global enable.
// - Capture enable routes output to timer capture.
// - Mode: toggle, reserved, falling, rising edge.
// - Mux enable and converter off select mux.
// - Low channel bits pick analog pin zero-seven.
// - Mux usable only when power reduction clear.
// - Digital disable bits gate pin buffers, read zero.
// - Converter on means control A enable set.
module acc_top
    import acc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input acc_pkg::acc_bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    input wire logic cmp_raw,
    input wire logic global_irq_enable,
    input wire logic irq_vector_ack,
    input wire logic pos_pin_in,
    input wire logic neg_pin_in,
    output acc_pkg::acc_analog_sel_t analog_sel,
    output logic pos_pin_dig_en,
    output logic neg_pin_dig_en,
    output logic pos_pin_port_bit,
    output logic neg_pin_port_bit,
    output logic capture_in,
    output logic cmp_irq_req,
    output logic block_irq
);
    import acc_pkg::*;

    // Reset release synchroniser; the whole block uses rst_n.
    logic rst_m_q;
    logic rst_n;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_m_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n <= rst_m_q;
        end
    end

    // Returns one when the chosen mode sees an event between two samples.
    function automatic logic edge_hit(input acc_mode_t mode, input logic cur, input logic prev);
        logic hit;
        hit = 1'b0;
        case (mode)
            ACC_MODE_TOGGLE: hit = cur ^ prev;
            ACC_MODE_FALL: hit = prev & ~cur;
            ACC_MODE_RISE: hit = cur & ~prev;
            default: hit = 1'b0; // The reserved code never raises the flag.
        endcase
        return hit;
    endfunction

    // Register state.
    logic power_off_q; // Comparator power switch.
    logic bandgap_q; // Positive input from the bandgap reference.
    logic flag_q; // Sticky comparator interrupt flag.
    logic irq_en_q; // Comparator interrupt enable.
    logic capture_q; // Route output to timer capture.
    logic [1:0] mode_q; // Interrupt mode field.
    logic [7:0] convb_q; // Converter control B image.
    logic [7:0] didr_q; // Digital input disable image.
    logic [7:0] conva_q; // Converter control A image.
    logic [7:0] chan_q; // Converter channel register image.
    logic [7:0] pwr_q; // Power reduction register image.
    logic [1:0] stat_q; // Block status: bit0 flag event, bit1 output change.
    logic [1:0] mask_q; // Mask of the same layout.
    logic [7:0] rdata_q; // Read data, valid the cycle after the strobe.

    // Decoded write strobes for the control and status registers; the others decode inline.
    logic wr_ctrl;
    logic wr_stat;
    assign wr_ctrl = bus_req.wr && (bus_req.addr == `ACC_OFF_CTRL);
    assign wr_stat = bus_req.wr && (bus_req.addr == `ACC_OFF_IRQ_STAT);

    // Synchronised comparator output and the value one cycle before.
    logic out_sync;
    logic out_prev;
    acc_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(cmp_raw),
        .sync_q(out_sync),
        .prev_q(out_prev)
    );

    // A powered-off comparator yields no valid result, so its output is forced low.
    logic out_valid;
    assign out_valid = out_sync & ~power_off_q;
    logic prev_valid_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_valid_q <= 1'b0;
        end else begin
            prev_valid_q <= out_valid;
        end
    end

    // Event detection on current versus previous synchronised value.
    logic cmp_event;
    assign cmp_event = edge_hit(acc_mode_t'(mode_q), out_valid, prev_valid_q);

    // Writable control bits of the comparator register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_off_q <= 1'b0;
            bandgap_q <= 1'b0;
            irq_en_q <= 1'b0;
            capture_q <= 1'b0;
            mode_q <= 2'h0;
        end else if (wr_ctrl) begin
            power_off_q <= bus_req.wdata[`ACC_BIT_POWER_OFF];
            bandgap_q <= bus_req.wdata[`ACC_BIT_BANDGAP];
            irq_en_q <= bus_req.wdata[`ACC_BIT_IRQ_EN];
            capture_q <= bus_req.wdata[`ACC_BIT_CAPTURE];
            mode_q <= bus_req.wdata[1:0];
        end
    end

    // Sticky flag: an event in the clearing cycle wins so it is never lost.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else if (cmp_event) begin
            flag_q <= 1'b1;
        end else if (irq_vector_ack || (wr_ctrl && bus_req.wdata[`ACC_BIT_FLAG])) begin
            flag_q <= 1'b0;
        end
    end

    // Plain registers shadowing the converter, power and digital disable bits this block reads, and the status mask.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            convb_q <= `ACC_RESET_BYTE;
            didr_q <= `ACC_RESET_BYTE;
            conva_q <= `ACC_RESET_BYTE;
            chan_q <= `ACC_RESET_BYTE;
            pwr_q <= `ACC_RESET_BYTE;
            mask_q <= 2'h0;
        end else if (bus_req.wr) begin
            if (bus_req.addr == `ACC_OFF_CONVB) begin
                convb_q <= bus_req.wdata;
            end else if (bus_req.addr == `ACC_OFF_DIDR) begin
                didr_q <= bus_req.wdata;
            end else if (bus_req.addr == `ACC_OFF_CONVA) begin
                conva_q <= bus_req.wdata;
            end else if (bus_req.addr == `ACC_OFF_CHAN) begin
                chan_q <= bus_req.wdata;
            end else if (bus_req.addr == `ACC_OFF_PWR) begin
                pwr_q <= bus_req.wdata;
            end else if (bus_req.addr == `ACC_OFF_IRQ_MASK) begin
                mask_q <= bus_req.wdata[1:0];
            end
        end
    end

    // Block status bits: set wins over write-one-to-clear.
    logic [1:0] stat_set;
    assign stat_set = {out_valid ^ prev_valid_q, cmp_event};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= 2'h0;
        end else begin
            stat_q <= stat_set | (stat_q & ~(wr_stat ? bus_req.wdata[1:0] : 2'h0));
        end
    end

    // Negative input from the mux only with the converter off and unpowered-down.
    logic neg_mux_sel;
    assign neg_mux_sel = convb_q[`ACC_BIT_NEG_MUX] & ~conva_q[`ACC_BIT_CONV_ON] & ~pwr_q[`ACC_BIT_CONV_PWR];

    // Analog selection is registered so the macro sees glitch-free controls.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            analog_sel <= '0;
        end else begin
            analog_sel.power_off <= power_off_q;
            analog_sel.pos_bandgap <= bandgap_q;
            analog_sel.neg_from_mux <= neg_mux_sel;
            analog_sel.channel <= chan_q[2:0];
        end
    end

    // Pin digital buffers; disabled pins read zero in the port register.
    logic pos_m_q;
    logic pos_s_q;
    logic neg_m_q;
    logic neg_s_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_m_q <= 1'b0;
            pos_s_q <= 1'b0;
            neg_m_q <= 1'b0;
            neg_s_q <= 1'b0;
        end else begin
            pos_m_q <= pos_pin_in;
            pos_s_q <= pos_m_q;
            neg_m_q <= neg_pin_in;
            neg_s_q <= neg_m_q;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_pin_port_bit <= 1'b0;
            neg_pin_port_bit <= 1'b0;
        end else begin
            pos_pin_port_bit <= pos_s_q & ~didr_q[`ACC_BIT_POS_DIG];
            neg_pin_port_bit <= neg_s_q & ~didr_q[`ACC_BIT_NEG_DIG];
        end
    end
    assign pos_pin_dig_en = ~didr_q[`ACC_BIT_POS_DIG];
    assign neg_pin_dig_en = ~didr_q[`ACC_BIT_NEG_DIG];

    // Capture routing; the timer's own enable is its business.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            capture_in <= 1'b0;
        end else begin
            capture_in <= capture_q & out_valid;
        end
    end

    // Interrupt outputs. Mode changes with enable set may fire, as software must avoid.
    assign cmp_irq_req = flag_q & irq_en_q & global_irq_enable;
    assign block_irq = |(stat_q & mask_q);

    // Read mux; unmapped addresses read zero.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (!bus_req.rd) begin
            rdata_q <= 8'h00;
        end else if (bus_req.addr == `ACC_OFF_CTRL) begin
            rdata_q <= {power_off_q, bandgap_q, out_valid, flag_q, irq_en_q, capture_q, mode_q};
        end else if (bus_req.addr == `ACC_OFF_CONVB) begin
            rdata_q <= convb_q;
        end else if (bus_req.addr == `ACC_OFF_DIDR) begin
            rdata_q <= didr_q;
        end else if (bus_req.addr == `ACC_OFF_CONVA) begin
            rdata_q <= conva_q;
        end else if (bus_req.addr == `ACC_OFF_CHAN) begin
            rdata_q <= chan_q;
        end else if (bus_req.addr == `ACC_OFF_PWR) begin
            rdata_q <= pwr_q;
        end else if (bus_req.addr == `ACC_OFF_IRQ_STAT) begin
            rdata_q <= {6'h00, stat_q};
        end else if (bus_req.addr == `ACC_OFF_IRQ_MASK) begin
            rdata_q <= {6'h00, mask_q};
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign bus_rdata = rdata_q;

    // A raw level held over two edges shows on the synchronised output at the third.
    sequence raw_high_seq;
        cmp_raw ##1 cmp_raw;
    endsequence
    sequence raw_low_seq;
        !cmp_raw ##1 !cmp_raw;
    endsequence
    sync_latency_a: assert property (@(posedge clk) disable iff (!rst_n)
        raw_high_seq |=> out_sync) else $error("sync output lost");
    sync_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        raw_low_seq |=> !out_sync) else $error("sync output stuck high");
    // Power off forces the output low and, one edge later, the capture line as well.
    power_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        power_off_q |-> !out_valid ##1 !capture_in) else $error("output seen while off");
    // Rising mode event sets the flag next cycle.
    sequence rise_seq;
        (mode_q == 2'h3) ##0 (out_valid && !prev_valid_q);
    endsequence
    flag_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
        rise_seq |=> flag_q) else $error("rise missed");
    // Falling mode event sets the flag.
    flag_fall_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mode_q == 2'h2 && !out_valid && prev_valid_q) |=> flag_q) else $error("fall missed");
    // Toggle mode flags an edge in either direction.
    flag_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mode_q == 2'h0 && out_valid != prev_valid_q) |=> flag_q) else $error("toggle missed");
    // Reserved mode never sets the flag.
    reserved_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mode_q == 2'h1 && !flag_q) |=> !$rose(flag_q) || $past(mode_q) != 2'h1) else $error("reserved set");
    // Vector acknowledge without event clears the flag.
    sequence vec_clear_seq;
        irq_vector_ack && !cmp_event;
    endsequence
    flag_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        vec_clear_seq |=> !flag_q) else $error("flag not cleared");
    // Writing a one to the flag clears it unless an event lands in the same cycle.
    flag_w1c_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_ctrl && bus_req.wdata[`ACC_BIT_FLAG] && !cmp_event) |=> !flag_q) else $error("flag write one failed");
    // Without acknowledge or a written one the flag holds, so a written zero is harmless.
    flag_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (flag_q && !irq_vector_ack && !(wr_ctrl && bus_req.wdata[`ACC_BIT_FLAG])) |=> flag_q) else $error("flag lost");
    // Request follows flag, enable and global enable.
    irq_req_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmp_irq_req |-> flag_q && irq_en_q && global_irq_enable) else $error("bad request");
    // Every flag event is recorded in status bit zero.
    stat_event_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmp_event |=> stat_q[0]) else $error("status event missed");
    // Capture output is off when routing is off.
    capture_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        !capture_q |=> !capture_in) else $error("capture leaked");
    // With routing on, a high output reaches the capture line one edge later.
    capture_on_a: assert property (@(posedge clk) disable iff (!rst_n)
        (capture_q && out_valid) |=> capture_in) else $error("capture not routed");
    // Mux selection forbidden while converter is on.
    neg_mux_a: assert property (@(posedge clk) disable iff (!rst_n)
        conva_q[`ACC_BIT_CONV_ON] |=> !analog_sel.neg_from_mux) else $error("mux with converter on");
    // Mux selection forbidden while the converter is powered down.
    mux_pwr_a: assert property (@(posedge clk) disable iff (!rst_n)
        pwr_q[`ACC_BIT_CONV_PWR] |=> !analog_sel.neg_from_mux) else $error("mux while powered down");
    // The channel field reaches the macro one edge after it is written.
    channel_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
        analog_sel.channel == $past(chan_q[2:0])) else $error("channel not passed");
    // Disabled positive pin reads zero.
    pin_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        didr_q[`ACC_BIT_POS_DIG] |=> !pos_pin_port_bit) else $error("disabled pin read one");
    // Disabled negative pin reads zero.
    neg_pin_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        didr_q[`ACC_BIT_NEG_DIG] |=> !neg_pin_port_bit) else $error("disabled negative pin read one");
    // Read data stands only in the cycle after a read strobe.
    read_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        !bus_req.rd |=> bus_rdata == 8'h00) else $error("stale read data");
endmodule

// ==== verif/acc_cpu_model.sv ====
// Behavioural model of the CPU interrupt logic and the timer capture unit beside the comparator block.
// Assumes the same clock and active-low reset as the block, and single-cycle vector acknowledges.
module acc_cpu_model #(
    parameter int ACK_DELAY = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic irq_req,
    input wire logic capture_in,
    input wire logic timer_capture_irq_enable,
    output logic irq_vector_ack,
    output logic [7:0] capture_count
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_q; // Cycles the request has been pending.
    logic cap_prev_q; // Last seen capture input, for edge detection.

    // The CPU takes the vector only after the request has stood a while, which exercises a slow answer.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_q <= 0;
            irq_vector_ack <= 1'b0;
        end else begin
            irq_vector_ack <= 1'b0;
            if (irq_req && !irq_vector_ack) begin
                if (wait_q == ACK_DELAY - 1) begin
                    irq_vector_ack <= 1'b1;
                    wait_q <= 0;
                end else begin
                    wait_q <= wait_q + 1;
                end
            end else begin
                wait_q <= 0;
            end
        end
    end

    // A capture interrupt counts only with the timer's capture enable set.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cap_prev_q <= 1'b0;
            capture_count <= 8'h00;
        end else begin
            cap_prev_q <= capture_in;
            if (capture_in && !cap_prev_q && timer_capture_irq_enable) begin
                capture_count <= capture_count + 8'h01;
            end
        end
    end
endmodule

// ==== verif/tb.sv ====
// Self-checking testbench of the comparator control block, driving its register port.
// Assumes the design sources and the CPU model are compiled first.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import acc_pkg::*;
    logic clk, reset_n, cmp_raw, global_irq_enable, irq_vector_ack, pos_pin_in, neg_pin_in;
    logic pos_pin_dig_en, neg_pin_dig_en, pos_pin_port_bit, neg_pin_port_bit, capture_in, cmp_irq_req, block_irq;
    acc_bus_req_t bus_req;
    acc_analog_sel_t analog_sel;
    logic [7:0] bus_rdata, capture_count;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;

    acc_top i_acc_top (.clk(clk), .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .cmp_raw(cmp_raw), .global_irq_enable(global_irq_enable), .irq_vector_ack(irq_vector_ack),
        .pos_pin_in(pos_pin_in), .neg_pin_in(neg_pin_in), .analog_sel(analog_sel),
        .pos_pin_dig_en(pos_pin_dig_en), .neg_pin_dig_en(neg_pin_dig_en), .pos_pin_port_bit(pos_pin_port_bit),
        .neg_pin_port_bit(neg_pin_port_bit), .capture_in(capture_in), .cmp_irq_req(cmp_irq_req),
        .block_irq(block_irq));
    acc_cpu_model #(.ACK_DELAY(4)) i_acc_cpu_model (.clk(clk), .reset_n(reset_n), .irq_req(cmp_irq_req),
        .capture_in(capture_in), .timer_capture_irq_enable(1'b1), .irq_vector_ack(irq_vector_ack),
        .capture_count(capture_count));

    // Free-running 50 MHz clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // A hang is cut short well beyond the few hundred cycles the tests need.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            summarize();
        end
    end

    // Waits n edges, then lets their updates settle before anything is sampled.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One-cycle write strobe; the release edge is the one that samples it.
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req <= '0;
    endtask

    // One-cycle read strobe; data is valid only in the following cycle.
    task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req <= '0;
        #1;
        chk(nm, e, bus_rdata);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        bus_req = '0;
        reset_n = 1'b0;
        cmp_raw = 1'b0;
        global_irq_enable = 1'b0;
        pos_pin_in = 1'b0;
        neg_pin_in = 1'b0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        cyc(3);
        // Reset values, the unmapped index and the read-only output bit.
        for (int a = 0; a < 9; a++) rchk("reset", a[3:0], 8'h00);
        wr(4'h8, 8'hff);
        rchk("unmapped", 4'h8, 8'h00);
        wr(4'h0, 8'h20);
        rchk("out_ro", 4'h0, 8'h00);
        // A rise in toggle mode shows on the output bit and sets the flag; only a one clears it.
        @(posedge clk);
        cmp_raw <= 1'b1;
        cyc(3);
        rchk("rise", 4'h0, 8'h30);
        wr(4'h0, 8'h00);
        rchk("w0_flag", 4'h0, 8'h30);
        wr(4'h0, 8'h10);
        rchk("w1_flag", 4'h0, 8'h20);
        // Every mode code against a fall and a rise; the reserved code never flags.
        for (int m = 0; m < 4; m++) begin
            wr(4'h0, 8'h10 | m[7:0]);
            cmp_raw <= 1'b0;
            cyc(4);
            rchk("fall", 4'h0, {3'b000, (m == 0 || m == 2), 2'b00, m[1:0]});
            wr(4'h0, 8'h10 | m[7:0]);
            cmp_raw <= 1'b1;
            cyc(4);
            rchk("rise", 4'h0, {3'b001, (m == 0 || m == 3), 2'b00, m[1:0]});
        end
        // Sticky status with mask drives the block interrupt line.
        rchk("stat", 4'h6, 8'h03);
        chk("blk_off", 8'h00, {7'b0, block_irq});
        wr(4'h7, 8'h01);
        cyc(1);
        chk("blk_on", 8'h01, {7'b0, block_irq});
        wr(4'h6, 8'h01);
        rchk("stat_w1c", 4'h6, 8'h02);
        chk("blk_clr", 8'h00, {7'b0, block_irq});
        wr(4'h7, 8'h00);
        // The request needs flag, enable and the global enable; the vector then clears the flag.
        wr(4'h0, 8'h0b);
        cyc(1);
        chk("req_nogie", 8'h00, {7'b0, cmp_irq_req});
        @(posedge clk);
        global_irq_enable <= 1'b1;
        cyc(1);
        chk("req", 8'h01, {7'b0, cmp_irq_req});
        cyc(8);
        chk("req_acked", 8'h00, {7'b0, cmp_irq_req});
        rchk("vec_clr", 4'h0, 8'h2b);
        wr(4'h0, 8'h03);
        cmp_raw <= 1'b0;
        cyc(4);
        @(posedge clk);
        cmp_raw <= 1'b1;
        cyc(4);
        chk("req_noen", 8'h00, {7'b0, cmp_irq_req});
        rchk("flag_noen", 4'h0, 8'h33);
        @(posedge clk);
        global_irq_enable <= 1'b0;
        // Power off forces the output low; bandgap selects the positive input.
        wr(4'h0, 8'h93);
        cyc(4);
        rchk("pwr_off", 4'h0, 8'h83);
        chk("sel_off", 8'h01, {7'b0, analog_sel.power_off});
        wr(4'h0, 8'h43);
        cyc(4);
        rchk("pwr_on", 4'h0, 8'h73);
        chk("sel_bg", 8'h01, {6'b0, analog_sel.power_off, analog_sel.pos_bandgap});
        wr(4'h0, 8'h10);
        // Negative input source over every mux, converter and power-reduce combination.
        for (int i = 0; i < 8; i++) begin
            wr(4'h1, {1'b0, i[2], 6'b0});
            wr(4'h3, {i[1], 7'b0});
            wr(4'h5, {7'b0, i[0]});
            wr(4'h4, {5'b0, i[2:0]});
            cyc(2);
            chk("neg_mux", {7'b0, i[2] && !i[1] && !i[0]}, {7'b0, analog_sel.neg_from_mux});
            chk("channel", {5'b0, i[2:0]}, {5'b0, analog_sel.channel});
        end
        // Digital input disables gate the buffers and force the port bits to zero.
        @(posedge clk);
        pos_pin_in <= 1'b1;
        neg_pin_in <= 1'b1;
        cyc(4);
        chk("pins_on", 8'h0f, {4'b0, pos_pin_dig_en, neg_pin_dig_en, pos_pin_port_bit, neg_pin_port_bit});
        wr(4'h2, 8'h01);
        cyc(4);
        chk("pos_off", 8'h05, {4'b0, pos_pin_dig_en, neg_pin_dig_en, pos_pin_port_bit, neg_pin_port_bit});
        wr(4'h2, 8'h03);
        cyc(4);
        chk("pins_off", 8'h00, {4'b0, pos_pin_dig_en, neg_pin_dig_en, pos_pin_port_bit, neg_pin_port_bit});
        rchk("didr", 4'h2, 8'h03);
        // Capture routing passes the output to the timer only while enabled.
        wr(4'h0, 8'h04);
        cyc(4);
        chk("cap_on", 8'h01, {7'b0, capture_in});
        chk("cap_cnt", 8'h01, capture_count);
        wr(4'h0, 8'h00);
        cmp_raw <= 1'b0;
        cyc(4);
        @(posedge clk);
        cmp_raw <= 1'b1;
        cyc(4);
        chk("cap_off", 8'h00, {7'b0, capture_in});
        chk("cap_cnt_off", 8'h01, capture_count);
        summarize();
    end
endmodule
